// ==== fpp_pkg.sv ====
// Constants, register indices and types shared by the fifteen-output PWM timer.
// Assumes a 32-bit AHB-Lite slave where each register index is one aligned word.
package fpp_pkg;
   localparam int unsigned NCH = 6;
   localparam int unsigned NSLOT = 4;
   localparam int unsigned NPIN = 15;
   localparam int unsigned CW = 16;
   localparam int unsigned IXW = 24;

   // Register indices; byte address is four times the index
   localparam logic [23:0] IX_RUN = 24'hFFFFBC;
   localparam logic [23:0] IX_SYNC = 24'hFFFFBD;
   localparam logic [23:0] IX_PERIOD_0 = 24'hFFFFC8;
   localparam logic [23:0] IX_W0_B = 24'hFFFFCA;
   localparam logic [23:0] IX_W0_C = 24'hFFFFCC;
   localparam logic [23:0] IX_W0_D = 24'hFFFFCE;
   localparam logic [23:0] IX_W1_A = 24'hFFFFD8;
   localparam logic [23:0] IX_W1_B = 24'hFFFFDA;
   localparam logic [23:0] IX_W2_A = 24'hFFFFE8;
   localparam logic [23:0] IX_W2_B = 24'hFFFFEA;
   localparam logic [23:0] IX_W3_A = 24'hFFFFF8;
   localparam logic [23:0] IX_W3_B = 24'hFFFFFA;
   localparam logic [23:0] IX_W3_C = 24'hFFFFFC;
   localparam logic [23:0] IX_W3_D = 24'hFFFFFE;
   localparam logic [23:0] IX_W4_A = 24'hFFFEE8;
   localparam logic [23:0] IX_W4_B = 24'hFFFEEA;
   localparam logic [23:0] IX_W5_A = 24'hFFFEF8;
   localparam logic [23:0] IX_W5_B = 24'hFFFEFA;
   localparam logic [23:0] IX_CFG_0 = 24'hFFFF00;
   localparam logic [23:0] IX_CNT_0 = 24'hFFFF10;
   localparam logic [23:0] IX_PINS = 24'hFFFF20;

   // Channel configuration word fields
   localparam int unsigned CCLS_LSB = 0;
   localparam int unsigned MODE_LSB = 4;
   localparam int unsigned IO_LSB = 16;

   // Clear source, mode and output control encodings
   localparam logic [2:0] CCLS_NONE = 3'h0;
   localparam logic [2:0] CCLS_A = 3'h1;
   localparam logic [2:0] CCLS_B = 3'h2;
   localparam logic [2:0] CCLS_SYNC = 3'h3;
   localparam logic [2:0] CCLS_C = 3'h5;
   localparam logic [2:0] CCLS_D = 3'h6;
   localparam logic [3:0] MODE_PWM2 = 4'h3;
   localparam logic [3:0] IO_CMP_SET = 4'h2;

   // Reset values
   localparam logic [31:0] CFG_RST_CH0 = 32'h2220_0031;
   localparam logic [31:0] CFG_RST_AB = 32'h0022_0033;
   localparam logic [31:0] CFG_RST_ABCD = 32'h2222_0033;
   localparam logic [15:0] CMP_RST = 16'hFFFF;
   localparam logic [5:0] RUN_RST = 6'h00;
   localparam logic [5:0] SYNC_RST = 6'h00;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WR = 4'b0010,
      ST_RWAIT = 4'b0100,
      ST_RDONE = 4'b1000
   } fpp_bus_st_t;
endpackage

// ==== fpp_chan.sv ====
// One timer channel: counter, four compare matches, clear logic and PWM mode 2 pins.
// Assumes compare values and configuration come from registers on the same clock.
module fpp_chan
   import fpp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   input wire logic sync_i,
   input wire logic [2:0] ccls_i,
   input wire logic [3:0] mode_i,
   input wire logic [15:0] ioctl_i,
   input wire logic [15:0] cmp_a_i,
   input wire logic [15:0] cmp_b_i,
   input wire logic [15:0] cmp_c_i,
   input wire logic [15:0] cmp_d_i,
   // Synchronous clear to and from other channels
   input wire logic sync_clr_i,
   output logic src_clr_o,
   // State and pins
   output logic [15:0] count_o,
   output logic [3:0] pin_o
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [3:0] pin_reg;
   logic [3:0] pin_next;
   logic [3:0] match;
   logic own_clr;
   logic sync_take;
   logic clr;
   logic [15:0] cmp [4];

   assign cmp[0] = cmp_a_i;
   assign cmp[1] = cmp_b_i;
   assign cmp[2] = cmp_c_i;
   assign cmp[3] = cmp_d_i;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         match[k] = run_i && (cnt_reg == cmp[k]);
      end
      own_clr = ((ccls_i == CCLS_A) && match[0]) ||
         ((ccls_i == CCLS_B) && match[1]) ||
         ((ccls_i == CCLS_C) && match[2]) ||
         ((ccls_i == CCLS_D) && match[3]);
      // A halted channel ignores the shared clear so its count really holds
      sync_take = run_i && sync_i && (ccls_i == CCLS_SYNC) && sync_clr_i;
      clr = own_clr || sync_take;
      src_clr_o = own_clr && sync_i;
      if (clr) begin
         cnt_next = '0;
      end else if (run_i) begin
         cnt_next = cnt_reg + 16'h0001;
      end else begin
         cnt_next = cnt_reg;
      end
      for (int k = 0; k < 4; k++) begin
         if (!((mode_i == MODE_PWM2) && (ioctl_i[4*k +: 4] == IO_CMP_SET))) begin
            pin_next[k] = 1'b0;
         end else if (clr) begin
            pin_next[k] = 1'b0;
         end else if (match[k]) begin
            pin_next[k] = 1'b1;
         end else begin
            pin_next[k] = pin_reg[k];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0000;
         pin_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
         pin_reg <= pin_next;
      end
   end

   assign count_o = cnt_reg;
   assign pin_o = pin_reg;

   property p_halt_holds;
      @(posedge clk_i) disable iff (rst_i)
      !run_i ##1 !run_i |-> $stable(cnt_reg);
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("halted counter moved");

   property p_run_advances;
      @(posedge clk_i) disable iff (rst_i)
      (run_i && !clr) |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
   endproperty
   a_run_advances: assert property (p_run_advances) else $error("counter did not step");

   property p_indep;
      @(posedge clk_i) disable iff (rst_i)
      (!sync_i && run_i && !own_clr) |=> (cnt_reg != 16'h0000 || $past(cnt_reg) == 16'hFFFF);
   endproperty
   a_indep: assert property (p_indep) else $error("independent channel was cleared");

   property p_sync_clear;
      @(posedge clk_i) disable iff (rst_i)
      (run_i && sync_i && ccls_i == CCLS_SYNC && sync_clr_i) |=> (cnt_reg == 16'h0000);
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("sync clear missed");

   property p_no_src_unsynced;
      @(posedge clk_i) disable iff (rst_i)
      !sync_i |-> !src_clr_o;
   endproperty
   a_no_src_unsynced: assert property (p_no_src_unsynced) else $error("unsynced clear shared");

   property p_period_clear;
      @(posedge clk_i) disable iff (rst_i)
      (ccls_i == CCLS_A && run_i && cnt_reg == cmp_a_i) |=> (cnt_reg == 16'h0000);
   endproperty
   a_period_clear: assert property (p_period_clear) else $error("period match no clear");

   property p_match_sets;
      @(posedge clk_i) disable iff (rst_i)
      (mode_i == MODE_PWM2 && ioctl_i[7:4] == IO_CMP_SET && match[1] && !clr) |=> pin_reg[1];
   endproperty
   a_match_sets: assert property (p_match_sets) else $error("match did not raise pin");

   property p_clear_lowers;
      @(posedge clk_i) disable iff (rst_i)
      clr |=> (pin_reg == 4'h0) ##1 (cnt_reg != 16'h0000 || !run_i || pin_reg == 4'h0);
   endproperty
   a_clear_lowers: assert property (p_clear_lowers) else $error("pin high after clear");
endmodule

// ==== fpp_timer.sv ====
// Fifteen-output PWM timer: six synchronised channels behind an AHB-Lite slave.
// Assumes one master, word transfers only, and a single clock at 25 MHz.
// How it works
// - Each width register is a compare value setting its pin's low time per period.
// - A channel whose run bit is clear holds its counter still.
// - A channel whose run bit is set counts on every clock.
// - A channel with sync bit clear neither gives nor takes shared clears.
// - Channels with sync bit set share clears with each other.
// - Channel 0 period register match clears channel 0 when selected as source.
// - Sync clear source resets a counter when another synced counter clears.
// - In PWM mode 2 with compare output, a match in a cycle with no clear drives the pin high.
// - The period register has no pin; only the fifteen widths drive pins.
module fpp_timer
   import fpp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // PWM pins
   output logic [14:0] pwm_output_pin_o
);
   fpp_bus_st_t st_reg;
   fpp_bus_st_t st_next;
   logic [23:0] idx_reg;
   logic [23:0] idx_next;
   logic ok_reg;
   logic ok_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] rd_val;
   logic accept;

   logic [5:0] run_reg;
   logic [5:0] run_next;
   logic [5:0] sync_reg;
   logic [5:0] sync_next;
   logic [31:0] cfg_reg [6];
   logic [31:0] cfg_next [6];
   logic [15:0] cmp_reg [6][4];
   logic [15:0] cmp_next [6][4];

   logic [15:0] cnt [6];
   logic [3:0] chpin [6];
   logic [5:0] src_clr;

   function automatic logic [31:0] cfg_rst(input int n);
      if (n == 0) begin
         return CFG_RST_CH0;
      end else if (n == 3) begin
         return CFG_RST_ABCD;
      end
      return CFG_RST_AB;
   endfunction

   // Bus phases: a read spends one wait state so hrdata comes from a flop
   always_comb begin
      st_next = st_reg;
      idx_next = idx_reg;
      ok_next = ok_reg;
      rdata_next = rdata_reg;
      accept = hsel_i && htrans_i[1] && hready_i;
      case (st_reg)
         ST_RWAIT: begin
            rdata_next = rd_val;
            st_next = ST_RDONE;
         end
         ST_IDLE, ST_WR, ST_RDONE: begin
            if (accept) begin
               idx_next = haddr_i[25:2];
               ok_next = (haddr_i[31:26] == 6'h00) && (haddr_i[1:0] == 2'h0);
               st_next = hwrite_i ? ST_WR : ST_RWAIT;
            end else begin
               st_next = ST_IDLE;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ST_IDLE;
         idx_reg <= 24'h000000;
         ok_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
         idx_reg <= idx_next;
         ok_reg <= ok_next;
         rdata_reg <= rdata_next;
      end
   end

   assign hreadyout_o = (st_reg != ST_RWAIT);
   assign hresp_o = 1'b0;
   assign hrdata_o = rdata_reg;

   // Register writes land at the end of the data phase
   always_comb begin
      run_next = run_reg;
      sync_next = sync_reg;
      for (int n = 0; n < 6; n++) begin
         cfg_next[n] = cfg_reg[n];
         for (int k = 0; k < 4; k++) begin
            cmp_next[n][k] = cmp_reg[n][k];
         end
      end
      if (st_reg == ST_WR && ok_reg) begin
         case (idx_reg)
            IX_RUN: run_next = hwdata_i[5:0];
            IX_SYNC: sync_next = hwdata_i[5:0];
            IX_PERIOD_0: cmp_next[0][0] = hwdata_i[15:0];
            IX_W0_B: cmp_next[0][1] = hwdata_i[15:0];
            IX_W0_C: cmp_next[0][2] = hwdata_i[15:0];
            IX_W0_D: cmp_next[0][3] = hwdata_i[15:0];
            IX_W1_A: cmp_next[1][0] = hwdata_i[15:0];
            IX_W1_B: cmp_next[1][1] = hwdata_i[15:0];
            IX_W2_A: cmp_next[2][0] = hwdata_i[15:0];
            IX_W2_B: cmp_next[2][1] = hwdata_i[15:0];
            IX_W3_A: cmp_next[3][0] = hwdata_i[15:0];
            IX_W3_B: cmp_next[3][1] = hwdata_i[15:0];
            IX_W3_C: cmp_next[3][2] = hwdata_i[15:0];
            IX_W3_D: cmp_next[3][3] = hwdata_i[15:0];
            IX_W4_A: cmp_next[4][0] = hwdata_i[15:0];
            IX_W4_B: cmp_next[4][1] = hwdata_i[15:0];
            IX_W5_A: cmp_next[5][0] = hwdata_i[15:0];
            IX_W5_B: cmp_next[5][1] = hwdata_i[15:0];
            default: begin
               for (int n = 0; n < 6; n++) begin
                  if (idx_reg == IX_CFG_0 + 24'(n)) begin
                     cfg_next[n] = hwdata_i;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= RUN_RST;
         sync_reg <= SYNC_RST;
         for (int n = 0; n < 6; n++) begin
            cfg_reg[n] <= cfg_rst(n);
            for (int k = 0; k < 4; k++) begin
               cmp_reg[n][k] <= CMP_RST;
            end
         end
      end else begin
         run_reg <= run_next;
         sync_reg <= sync_next;
         for (int n = 0; n < 6; n++) begin
            cfg_reg[n] <= cfg_next[n];
            for (int k = 0; k < 4; k++) begin
               cmp_reg[n][k] <= cmp_next[n][k];
            end
         end
      end
   end

   property p_run_write;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg == ST_WR && ok_reg && idx_reg == IX_RUN)
         |=> (run_reg == $past(hwdata_i[5:0]));
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bits not written");

   property p_sync_write;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg == ST_WR && ok_reg && idx_reg == IX_SYNC)
         |=> (sync_reg == $past(hwdata_i[5:0]));
   endproperty
   a_sync_write: assert property (p_sync_write) else $error("sync bits not written");

   // Read mux; unmapped or misaligned reads return zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (ok_reg) begin
         case (idx_reg)
            IX_RUN: rd_val = {26'h0000000, run_reg};
            IX_SYNC: rd_val = {26'h0000000, sync_reg};
            IX_PERIOD_0: rd_val = {16'h0000, cmp_reg[0][0]};
            IX_W0_B: rd_val = {16'h0000, cmp_reg[0][1]};
            IX_W0_C: rd_val = {16'h0000, cmp_reg[0][2]};
            IX_W0_D: rd_val = {16'h0000, cmp_reg[0][3]};
            IX_W1_A: rd_val = {16'h0000, cmp_reg[1][0]};
            IX_W1_B: rd_val = {16'h0000, cmp_reg[1][1]};
            IX_W2_A: rd_val = {16'h0000, cmp_reg[2][0]};
            IX_W2_B: rd_val = {16'h0000, cmp_reg[2][1]};
            IX_W3_A: rd_val = {16'h0000, cmp_reg[3][0]};
            IX_W3_B: rd_val = {16'h0000, cmp_reg[3][1]};
            IX_W3_C: rd_val = {16'h0000, cmp_reg[3][2]};
            IX_W3_D: rd_val = {16'h0000, cmp_reg[3][3]};
            IX_W4_A: rd_val = {16'h0000, cmp_reg[4][0]};
            IX_W4_B: rd_val = {16'h0000, cmp_reg[4][1]};
            IX_W5_A: rd_val = {16'h0000, cmp_reg[5][0]};
            IX_W5_B: rd_val = {16'h0000, cmp_reg[5][1]};
            IX_PINS: rd_val = {17'h00000, pwm_output_pin_o};
            default: begin
               for (int n = 0; n < 6; n++) begin
                  if (idx_reg == IX_CFG_0 + 24'(n)) begin
                     rd_val = cfg_reg[n];
                  end
                  if (idx_reg == IX_CNT_0 + 24'(n)) begin
                     rd_val = {16'h0000, cnt[n]};
                  end
               end
            end
         endcase
      end
   end

   // Channels share a clear only among those with their sync bit set
   for (genvar n = 0; n < 6; n++) begin : g_ch
      logic sync_in;
      assign sync_in = |(src_clr & ~(6'h01 << n));
      fpp_chan u_chan (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .run_i(run_reg[n]),
         .sync_i(sync_reg[n]),
         .ccls_i(cfg_reg[n][CCLS_LSB +: 3]),
         .mode_i(cfg_reg[n][MODE_LSB +: 4]),
         .ioctl_i(cfg_reg[n][IO_LSB +: 16]),
         .cmp_a_i(cmp_reg[n][0]),
         .cmp_b_i(cmp_reg[n][1]),
         .cmp_c_i(cmp_reg[n][2]),
         .cmp_d_i(cmp_reg[n][3]),
         .sync_clr_i(sync_in),
         .src_clr_o(src_clr[n]),
         .count_o(cnt[n]),
         .pin_o(chpin[n])
      );
   end

   // Slot A of channel 0 is the period compare and is left off the pins
   assign pwm_output_pin_o = {chpin[5][1:0], chpin[4][1:0], chpin[3],
      chpin[2][1:0], chpin[1][1:0], chpin[0][3:1]};

   property p_width_rise;
      @(posedge clk_i) disable iff (rst_i)
      $rose(pwm_output_pin_o[0]) |-> ($past(cnt[0]) == $past(cmp_reg[0][1]));
   endproperty
   a_width_rise: assert property (p_width_rise) else $error("pin 0 rose off its width");

   property p_no_period_pin;
      @(posedge clk_i) disable iff (rst_i)
      ($past(cnt[0]) == $past(cmp_reg[0][0]) && $past(cnt[0]) != $past(cmp_reg[0][1])
         && $past(cnt[0]) != $past(cmp_reg[0][2]) && $past(cnt[0]) != $past(cmp_reg[0][3]))
         |-> !($rose(pwm_output_pin_o[0]) || $rose(pwm_output_pin_o[1])
         || $rose(pwm_output_pin_o[2]));
   endproperty
   a_no_period_pin: assert property (p_no_period_pin) else $error("period match drove a pin");

   property p_sync_follow;
      @(posedge clk_i) disable iff (rst_i)
      (src_clr[0] && sync_reg[1] && run_reg[1] && cfg_reg[1][2:0] == CCLS_SYNC)
         |=> (cnt[1] == 16'h0000 && cnt[0] == 16'h0000);
   endproperty
   a_sync_follow: assert property (p_sync_follow) else $error("channels did not clear together");

   property p_read_wait;
      @(posedge clk_i) disable iff (rst_i)
      (accept && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

   // Read data must stand until the next read so a slow master still sees it
   property p_rdata_stands;
      @(posedge clk_i) disable iff (rst_i)
      (st_reg != ST_RWAIT) |=> $stable(hrdata_o);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed early");

   property p_unsynced_counts;
      @(posedge clk_i) disable iff (rst_i)
      (!sync_reg[2] && run_reg[2] && cfg_reg[2][2:0] == CCLS_SYNC)
         |=> (cnt[2] == $past(cnt[2]) + 16'h0001);
   endproperty
   a_unsynced_counts: assert property (p_unsynced_counts) else $error("unsynced channel cleared");

   property p_ch0_sync_src;
      @(posedge clk_i) disable iff (rst_i)
      (sync_reg[0] && run_reg[0] && cfg_reg[0][2:0] == CCLS_A && cnt[0] == cmp_reg[0][0])
         |-> src_clr[0];
   endproperty
   a_ch0_sync_src: assert property (p_ch0_sync_src) else $error("period clear not shared");

   property p_sync_lowers;
      @(posedge clk_i) disable iff (rst_i)
      (src_clr[0] && sync_reg[3] && run_reg[3] && cfg_reg[3][2:0] == CCLS_SYNC)
         |=> (chpin[3] == 4'h0);
   endproperty
   a_sync_lowers: assert property (p_sync_lowers) else $error("shared clear left pin high");

   property p_width_rise_ch5;
      @(posedge clk_i) disable iff (rst_i)
      $rose(pwm_output_pin_o[13]) |-> ($past(cnt[5]) == $past(cmp_reg[5][0]));
   endproperty
   a_width_rise_ch5: assert property (p_width_rise_ch5) else $error("pin 13 rose off width");
endmodule

// ==== fpp_timer_test.sv ====
// Self-checking bench for the fifteen-output PWM timer, driven over AHB-Lite.
// Assumes the design answers writes with no wait state and reads with one.
module fpp_timer_test;
   import fpp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [14:0] pwm;
   int fails = 0;
   int compares = 0;
   logic [31:0] rdat;
   logic [15:0] wexp [15];
   logic [14:0] pin_mdl;
   logic [14:0] pin_mask;
   logic [15:0] cnt_mdl;
   logic [23:0] wix [15] = '{IX_W0_B, IX_W0_C, IX_W0_D, IX_W1_A, IX_W1_B, IX_W2_A, IX_W2_B,
      IX_W3_A, IX_W3_B, IX_W3_C, IX_W3_D, IX_W4_A, IX_W4_B, IX_W5_A, IX_W5_B};
   logic [31:0] cfg_rst [6] = '{CFG_RST_CH0, CFG_RST_AB, CFG_RST_AB, CFG_RST_ABCD, CFG_RST_AB,
      CFG_RST_AB};

   // Single slave, so its ready is the bus ready
   fpp_timer dut (
      .clk_i(clk),
      .rst_i(rst),
      .hsel_i(hsel),
      .haddr_i(haddr),
      .htrans_i(htrans),
      .hwrite_i(hwrite),
      .hsize_i(hsize),
      .hwdata_i(hwdata),
      .hready_i(hreadyout),
      .hreadyout_o(hreadyout),
      .hresp_o(hresp),
      .hrdata_o(hrdata),
      .pwm_output_pin_o(pwm)
   );

   always #20 clk = ~clk;

   task automatic test_done();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Entered just after a rising edge; returns at the edge that ends the data phase
   task automatic bus_xfer(input logic wr, input logic [23:0] ix, input logic [31:0] wd,
         output logic [31:0] rd);
      haddr <= {6'h00, ix, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel <= 1'b1;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      `CHECK(hresp, 1'b0)
   endtask

   task automatic reg_wr(input logic [23:0] ix, input logic [31:0] wd);
      logic [31:0] unused;
      bus_xfer(1'b1, ix, wd, unused);
   endtask

   task automatic reg_chk(input logic [23:0] ix, input logic [31:0] exp);
      logic [31:0] rd;
      bus_xfer(1'b0, ix, 32'h0000_0000, rd);
      `CHECK(rd, exp)
   endtask

   task automatic do_reset();
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask

   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      #(40 * 20000);
      fails++;
      test_done();
   end

   initial begin
      @(posedge clk);
      do_reset();
      `CHECK(pwm, 15'h0000)
      // Reset values of every register except the counters
      for (int k = 0; k < 15; k++) reg_chk(wix[k], 32'h0000_FFFF);
      reg_chk(IX_PERIOD_0, 32'h0000_FFFF);
      reg_chk(IX_RUN, 32'h0000_0000);
      reg_chk(IX_SYNC, 32'h0000_0000);
      for (int n = 0; n < 6; n++) reg_chk(IX_CFG_0 + 24'(n), cfg_rst[n]);
      reg_chk(IX_PINS, 32'h0000_0000);
      // Unmapped place: write ignored, reads zero
      reg_wr(24'h000100, 32'h1234_5678);
      reg_chk(24'h000100, 32'h0000_0000);
      // Width registers with the fifteen staggered settings, written then read back
      for (int k = 0; k < 15; k++) wexp[k] = 16'h0EFF - 16'(k) * 16'h0100;
      for (int k = 0; k < 15; k++) reg_wr(wix[k], {16'h0000, wexp[k]});
      for (int k = 0; k < 15; k++) reg_chk(wix[k], {16'h0000, wexp[k]});
      // Independent channels: only ch0 wraps on its period, others keep counting
      reg_wr(IX_PERIOD_0, 32'h0000_0028);
      reg_wr(IX_RUN, 32'h0000_003F);
      repeat (100) @(posedge clk);
      reg_wr(IX_RUN, 32'h0000_0000);
      // 102 steps in all: ch0 wraps every 41 counts
      reg_chk(IX_CNT_0, 32'h0000_0014);
      for (int n = 1; n < 6; n++) reg_chk(IX_CNT_0 + 24'(n), 32'h0000_0066);
      repeat (10) @(posedge clk);
      reg_chk(IX_CNT_0, 32'h0000_0014);
      reg_chk(IX_CNT_0 + 24'h000003, 32'h0000_0066);
      `CHECK(pwm, 15'h0000)
      // Second reset after the halted run clears counters and pins
      do_reset();
      `CHECK(pwm, 15'h0000)
      reg_chk(IX_CNT_0, 32'h0000_0000);
      reg_chk(IX_W0_B, 32'h0000_FFFF);
      // Synchronised PWM run with short widths; ch5 slot B has its output disabled
      for (int k = 0; k < 15; k++) wexp[k] = 16'(2 + 2 * k);
      for (int k = 0; k < 15; k++) reg_wr(wix[k], {16'h0000, wexp[k]});
      reg_wr(IX_PERIOD_0, 32'h0000_0028);
      reg_wr(IX_CFG_0 + 24'h000005, 32'h0002_0033);
      reg_wr(IX_SYNC, 32'h0000_003F);
      reg_chk(IX_SYNC, 32'h0000_003F);
      pin_mask = 15'h3FFF;
      reg_wr(IX_RUN, 32'h0000_003F);
      cnt_mdl = 16'h0000;
      pin_mdl = 15'h0000;
      for (int c = 0; c < 90; c++) begin
         @(negedge clk);
         `CHECK(pwm, pin_mdl)
         if (cnt_mdl == 16'h0028) begin
            cnt_mdl = 16'h0000;
            pin_mdl = 15'h0000;
         end else begin
            for (int k = 0; k < 15; k++) begin
               if (cnt_mdl == wexp[k]) pin_mdl[k] = pin_mask[k];
            end
            cnt_mdl = cnt_mdl + 16'h0001;
         end
      end
      @(posedge clk);
      // Halting freezes the pins at their current level
      reg_wr(IX_RUN, 32'h0000_0000);
      // 92 steps leave count 10, so only the widths 2 to 8 are already high
      @(negedge clk);
      pin_mdl = 15'h000F;
      repeat (20) @(negedge clk);
      `CHECK(pwm, pin_mdl)
      @(posedge clk);
      reg_chk(IX_PINS, {17'h00000, pin_mdl});
      reg_chk(IX_CNT_0, 32'h0000_000A);
      // Own-slot clear sources C, B and D: 21 steps on periods of 4, 6 and 8 counts
      do_reset();
      reg_wr(IX_CFG_0, 32'h2220_0035);
      reg_wr(IX_CFG_0 + 24'h000001, 32'h0022_0032);
      reg_wr(IX_CFG_0 + 24'h000003, 32'h2222_0036);
      reg_wr(IX_W0_C, 32'h0000_0003);
      reg_wr(IX_W1_B, 32'h0000_0005);
      reg_wr(IX_W3_D, 32'h0000_0007);
      reg_wr(IX_RUN, 32'h0000_000B);
      repeat (19) @(posedge clk);
      reg_wr(IX_RUN, 32'h0000_0000);
      reg_chk(IX_CNT_0, 32'h0000_0001);
      reg_chk(IX_CNT_0 + 24'h000001, 32'h0000_0003);
      reg_chk(IX_CNT_0 + 24'h000002, 32'h0000_0000);
      reg_chk(IX_CNT_0 + 24'h000003, 32'h0000_0005);
      `CHECK(pwm, 15'h0000)
      test_done();
   end
endmodule
